//--- rtl/csco_unit.sv
// Purpose: Status word, constant generator, register file and operand mode decode of a 16-bit core.
// Assumes: Decoder, execute stage and clock system sit outside; one clock, async reset.
// Notes: Decode answers one cycle after the request; register updates land at the same edge.
module csco_unit
    import csco_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int NUM_GPR = 12
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Decoder side
    input wire csco_dec_s i_dec,
    output csco_opnd_s o_opnd,
    // Execute side
    input wire csco_alu_s i_alu,
    input wire csco_wb_s i_wb,
    input wire logic i_pc_step,
    input wire logic i_pc_load,
    input wire logic [15:0] i_pc_value,
    // Clock system and interrupt side
    input wire logic i_dco_drives_main,
    input wire logic i_dco_drives_sub,
    input wire logic i_lfxt_drives_main,
    input wire logic i_lfxt_drives_sub,
    input wire logic i_irq_request,
    // Status and control outputs
    output logic [15:0] o_processor_status_word,
    output logic [15:0] o_program_counter,
    output logic o_sub_clock_off,
    output logic o_dco_gen_off,
    output logic o_lfxt_off,
    output logic o_core_halt,
    output logic o_irq_accept
);

    // Fixed-width structure: refuse anything else at elaboration
    if (DATA_W != 16 || NUM_GPR != 12) begin : g_bad_params
        $error("csco_unit supports only DATA_W 16 and NUM_GPR 12");
    end

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] psw;
        logic [11:0][15:0] gpr;
        csco_opnd_s opnd;
    } csco_state_s;

    csco_state_s state_reg;
    csco_state_s state_next;

    // Plain register read; the constant-only register has no storage
    function automatic logic [15:0] csco_read(input csco_state_s s, input logic [3:0] idx);
        logic [3:0] gi;
        gi = 4'(idx - CSCO_REG_GPR0);
        case (idx)
            CSCO_REG_PC: csco_read = s.pc;
            CSCO_REG_SP: csco_read = s.sp;
            CSCO_REG_PSW: csco_read = s.psw;
            CSCO_REG_CONST: csco_read = CSCO_K_ZERO;
            default: csco_read = s.gpr[gi];
        endcase
    endfunction : csco_read

    // Source operand resolution
    logic [15:0] src_raw;
    logic [15:0] src_val;
    csco_kind_e src_kind;
    logic src_ext;
    logic src_inc;
    logic [15:0] src_step;

    always_comb begin
        src_raw = csco_read(state_reg, i_dec.src_reg);
        src_val = src_raw;
        src_kind = CSCO_K_REG;
        src_ext = 1'b0;
        src_inc = 1'b0;
        src_step = i_dec.byte_op ? CSCO_STEP_BYTE : CSCO_STEP_WORD;
        if (i_dec.src_reg == CSCO_REG_CONST) begin
            // Constants come out of the mux; no extension word is requested
            src_kind = CSCO_K_CONST;
            case (i_dec.src_mode)
                CSCO_AS_REG: src_val = CSCO_K_ZERO;
                CSCO_AS_IDX: src_val = CSCO_K_ONE;
                CSCO_AS_IND: src_val = CSCO_K_TWO;
                default: src_val = CSCO_K_MINUS1;
            endcase
        end else if (i_dec.src_reg == CSCO_REG_PSW && i_dec.src_mode != CSCO_AS_REG) begin
            case (i_dec.src_mode)
                CSCO_AS_IDX: begin
                    src_kind = CSCO_K_ABSOLUTE;
                    src_val = CSCO_K_ZERO;
                    src_ext = 1'b1;
                end
                CSCO_AS_IND: begin
                    src_kind = CSCO_K_CONST;
                    src_val = CSCO_K_FOUR;
                end
                default: begin
                    src_kind = CSCO_K_CONST;
                    src_val = CSCO_K_EIGHT;
                end
            endcase
        end else begin
            case (i_dec.src_mode)
                CSCO_AS_REG: begin
                    src_kind = CSCO_K_REG;
                    src_val = i_dec.byte_op ? (src_raw & CSCO_BYTE_MASK) : src_raw;
                end
                CSCO_AS_IDX: begin
                    // Base register value; the index word follows the instruction
                    src_kind = (i_dec.src_reg == CSCO_REG_PC) ? CSCO_K_SYMBOLIC : CSCO_K_INDEXED;
                    src_ext = 1'b1;
                end
                CSCO_AS_IND: begin
                    src_kind = CSCO_K_INDIRECT;
                end
                default: begin
                    src_inc = 1'b1;
                    if (i_dec.src_reg == CSCO_REG_PC) begin
                        // Counter stays even, so it always steps a whole word
                        src_kind = CSCO_K_IMMEDIATE;
                        src_ext = 1'b1;
                        src_step = CSCO_STEP_WORD;
                    end else begin
                        src_kind = CSCO_K_AUTOINC;
                    end
                end
            endcase
        end
    end

    // Destination resolution, independent of the source mode
    logic [15:0] dst_raw;
    csco_kind_e dst_kind;

    always_comb begin
        dst_raw = csco_read(state_reg, i_dec.dst_reg);
        dst_kind = CSCO_K_REG;
        if (i_dec.dst_mode) begin
            if (i_dec.dst_reg == CSCO_REG_PSW) begin
                dst_kind = CSCO_K_ABSOLUTE;
                dst_raw = CSCO_K_ZERO;
            end else if (i_dec.dst_reg == CSCO_REG_PC) begin
                dst_kind = CSCO_K_SYMBOLIC;
            end else begin
                dst_kind = CSCO_K_INDEXED;
            end
        end
    end

    // Flag computation from the execute result
    logic r_msb;
    logic a_msb;
    logic b_msb;
    logic f_zero;
    logic f_ovf;

    always_comb begin
        r_msb = i_alu.byte_op ? i_alu.result[7] : i_alu.result[15];
        a_msb = i_alu.byte_op ? i_alu.dst[7] : i_alu.dst[15];
        b_msb = i_alu.byte_op ? i_alu.src[7] : i_alu.src[15];
        f_zero = i_alu.byte_op ? (i_alu.result[7:0] == 8'h00) : (i_alu.result == 16'h0000);
        case (i_alu.op)
            CSCO_OP_ADD, CSCO_OP_SUM_WITH_CARRY_INSTR: f_ovf = (a_msb == b_msb) && (r_msb != a_msb);
            CSCO_OP_SUB, CSCO_OP_SUBC: f_ovf = (a_msb != b_msb) && (r_msb != a_msb);
            default: f_ovf = 1'b0;
        endcase
    end

    // Next state: program counter, flags, write-back, autoincrement, decode result
    logic [3:0] wb_gi;
    logic [3:0] inc_gi;
    logic [15:0] wb_data;
    logic [15:0] inc_value;

    always_comb begin
        state_next = state_reg;
        wb_gi = 4'(i_wb.dst_reg - CSCO_REG_GPR0);
        inc_gi = 4'(i_dec.src_reg - CSCO_REG_GPR0);
        wb_data = i_wb.byte_op ? (i_wb.data & CSCO_BYTE_MASK) : i_wb.data;
        inc_value = 16'(src_raw + src_step);
        // Program counter: load is forced even, step is one word
        if (i_pc_load) begin
            state_next.pc = {i_pc_value[15:1], 1'b0};
        end else if (i_pc_step) begin
            state_next.pc = 16'(state_reg.pc + CSCO_STEP_WORD);
        end
        // Flags of the finished operation
        if (i_alu.valid) begin
            state_next.psw[CSCO_PSW_N] = r_msb;
            state_next.psw[CSCO_PSW_Z] = f_zero;
            state_next.psw[CSCO_PSW_C] = i_alu.carry;
            state_next.psw[CSCO_PSW_V] = f_ovf;
        end
        // Pointer bump; a write-back below to the same register takes precedence
        if (i_dec.valid && src_inc) begin
            case (i_dec.src_reg)
                CSCO_REG_PC: state_next.pc = inc_value;
                CSCO_REG_SP: state_next.sp = inc_value;
                default: state_next.gpr[inc_gi] = inc_value;
            endcase
        end
        // Write-back; the constant-only register swallows writes
        if (i_wb.valid) begin
            case (i_wb.dst_reg)
                CSCO_REG_PC: state_next.pc = {wb_data[15:1], 1'b0};
                CSCO_REG_SP: state_next.sp = wb_data;
                CSCO_REG_PSW: begin
                    // Byte writes to the status word are not a register-mode word access
                    if (!i_wb.byte_op) begin
                        state_next.psw = wb_data & CSCO_PSW_USED;
                    end
                end
                CSCO_REG_CONST: state_next.psw = state_next.psw;
                default: state_next.gpr[wb_gi] = wb_data;
            endcase
        end
        // Registered decode answer
        state_next.opnd.valid = i_dec.valid;
        if (i_dec.valid) begin
            state_next.opnd.src_kind = src_kind;
            state_next.opnd.src_value = src_val;
            state_next.opnd.src_ext = src_ext;
            state_next.opnd.dst_kind = dst_kind;
            state_next.opnd.dst_value = dst_raw;
            state_next.opnd.dst_ext = i_dec.dst_mode;
        end
    end

    // State register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= '0;
            state_reg.pc <= CSCO_RST_REG;
            state_reg.psw <= CSCO_RST_PSW;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs from the state register, the oscillator-off and interrupt ones gated by inputs; clock system gating needs no extra delay
    assign o_opnd = state_reg.opnd;
    assign o_processor_status_word = state_reg.psw;
    assign o_program_counter = state_reg.pc;
    assign o_sub_clock_off = state_reg.psw[CSCO_PSW_GEN1];
    assign o_dco_gen_off = state_reg.psw[CSCO_PSW_GEN0] && !i_dco_drives_main && !i_dco_drives_sub;
    assign o_lfxt_off = state_reg.psw[CSCO_PSW_LOW_FREQ_OSCILLATOR_DISABLE] && !i_lfxt_drives_main && !i_lfxt_drives_sub;
    assign o_core_halt = state_reg.psw[CSCO_PSW_HALT];
    assign o_irq_accept = i_irq_request && state_reg.psw[CSCO_PSW_GIE];

    // Checks
    const_r3_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_dec.valid && i_dec.src_reg == CSCO_REG_CONST && i_dec.src_mode == CSCO_AS_INC
        |=> o_opnd.valid && o_opnd.src_value == 16'hffff && !o_opnd.src_ext)
        else $error("constant register mode 11 did not give minus one");

    const_r2_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_dec.valid && i_dec.src_reg == CSCO_REG_PSW && i_dec.src_mode == CSCO_AS_IND
        |=> o_opnd.src_value == 16'h0004 && o_opnd.src_kind == CSCO_K_CONST)
        else $error("status register mode 10 did not give four");

    no_ext_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_opnd.valid && o_opnd.src_kind == CSCO_K_CONST |-> !o_opnd.src_ext)
        else $error("generated constant requested an extension word");

    add_ovf_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_alu.valid && i_alu.op == CSCO_OP_ADD && !i_alu.byte_op && !i_wb.valid
        && !i_alu.dst[15] && !i_alu.src[15] && i_alu.result[15]
        |=> o_processor_status_word[8] && o_processor_status_word[2])
        else $error("positive plus positive negative did not set overflow");

    sub_ovf_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_alu.valid && (i_alu.op == CSCO_OP_SUB || i_alu.op == CSCO_OP_SUBC) && !i_wb.valid
        && (i_alu.byte_op ? i_alu.dst[7] == i_alu.src[7] : i_alu.dst[15] == i_alu.src[15])
        |=> !o_processor_status_word[8])
        else $error("subtract of like signs set overflow");

    byte_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_alu.valid && i_alu.byte_op && !i_wb.valid && i_alu.result[7:0] == 8'h00
        |=> o_processor_status_word[1] && !o_processor_status_word[2])
        else $error("zero byte result did not set zero flag");

    pc_even_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        !o_program_counter[0])
        else $error("program counter odd");

    pc_step_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_pc_step && !i_pc_load && !i_wb.valid && !(i_dec.valid && src_inc && i_dec.src_reg == CSCO_REG_PC)
        |=> o_program_counter == 16'($past(o_program_counter) + 16'h0002))
        else $error("program counter step was not one word");

    irq_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_irq_accept |-> o_processor_status_word[3] && i_irq_request)
        else $error("interrupt accepted while masked");

    byte_wb_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_wb.valid && i_wb.byte_op && i_wb.dst_reg == 4'h7 ##2 i_dec.valid && !i_wb.valid
        && i_dec.src_reg == 4'h7 && i_dec.src_mode == CSCO_AS_REG && !i_dec.byte_op
        |=> o_opnd.src_value[15:8] == 8'h00)
        else $error("byte write left upper byte set");

    autoinc_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_dec.valid && i_dec.src_reg == 4'h6 && i_dec.src_mode == CSCO_AS_INC && i_dec.byte_op && !i_wb.valid
        ##1 i_dec.valid && !i_wb.valid && i_dec.src_reg == 4'h6 && i_dec.src_mode == CSCO_AS_REG
        |=> o_opnd.src_value[7:0] == 8'($past(o_opnd.src_value[7:0]) + 8'h01))
        else $error("byte autoincrement did not add one");

    halt_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_core_halt == o_processor_status_word[4] && o_sub_clock_off == o_processor_status_word[7])
        else $error("halt or sub-clock output disagrees with status word");

endmodule : csco_unit

//--- rtl/csco_pkg.sv
// Purpose: Shared constants and carriers for the status, constant and operand unit.
// Assumes: 16-bit core, register numbers 0..15, two-bit source and one-bit destination modes.
// Notes: Status word bit positions and constant values are named here; the unit's assertions repeat some as literals.
package csco_pkg;

    // Register numbers with dedicated roles
    localparam logic [3:0] CSCO_REG_PC = 4'h0;
    localparam logic [3:0] CSCO_REG_SP = 4'h1;
    localparam logic [3:0] CSCO_REG_PSW = 4'h2;
    localparam logic [3:0] CSCO_REG_CONST = 4'h3;
    localparam logic [3:0] CSCO_REG_GPR0 = 4'h4;

    // Source mode field encodings
    localparam logic [1:0] CSCO_AS_REG = 2'h0;
    localparam logic [1:0] CSCO_AS_IDX = 2'h1;
    localparam logic [1:0] CSCO_AS_IND = 2'h2;
    localparam logic [1:0] CSCO_AS_INC = 2'h3;

    // Status word bit positions
    localparam int CSCO_PSW_C = 0;
    localparam int CSCO_PSW_Z = 1;
    localparam int CSCO_PSW_N = 2;
    localparam int CSCO_PSW_GIE = 3;
    localparam int CSCO_PSW_HALT = 4;
    localparam int CSCO_PSW_LOW_FREQ_OSCILLATOR_DISABLE = 5;
    localparam int CSCO_PSW_GEN0 = 6;
    localparam int CSCO_PSW_GEN1 = 7;
    localparam int CSCO_PSW_V = 8;
    localparam logic [15:0] CSCO_PSW_USED = 16'h01ff;

    // Reset values
    localparam logic [15:0] CSCO_RST_PSW = 16'h0000;
    localparam logic [15:0] CSCO_RST_REG = 16'h0000;

    // Generated constants
    localparam logic [15:0] CSCO_K_ZERO = 16'h0000;
    localparam logic [15:0] CSCO_K_ONE = 16'h0001;
    localparam logic [15:0] CSCO_K_TWO = 16'h0002;
    localparam logic [15:0] CSCO_K_FOUR = 16'h0004;
    localparam logic [15:0] CSCO_K_EIGHT = 16'h0008;
    localparam logic [15:0] CSCO_K_MINUS1 = 16'hffff;

    // Pointer steps
    localparam logic [15:0] CSCO_STEP_BYTE = 16'h0001;
    localparam logic [15:0] CSCO_STEP_WORD = 16'h0002;
    localparam logic [15:0] CSCO_BYTE_MASK = 16'h00ff;

    // Arithmetic class of the operation that updates the flags
    typedef enum logic [2:0] {CSCO_OP_ADD, CSCO_OP_SUM_WITH_CARRY_INSTR, CSCO_OP_SUB, CSCO_OP_SUBC, CSCO_OP_OTHER} csco_op_e;

    // Resolved operand kind
    typedef enum logic [3:0] {
        CSCO_K_REG, CSCO_K_INDEXED, CSCO_K_SYMBOLIC, CSCO_K_ABSOLUTE,
        CSCO_K_INDIRECT, CSCO_K_AUTOINC, CSCO_K_IMMEDIATE, CSCO_K_CONST
    } csco_kind_e;

    // Decode request from the instruction decoder
    typedef struct packed {
        logic valid;
        logic byte_op;
        logic [3:0] src_reg;
        logic [1:0] src_mode;
        logic [3:0] dst_reg;
        logic dst_mode;
    } csco_dec_s;

    // Decoded operands, one cycle after the request
    typedef struct packed {
        logic valid;
        csco_kind_e src_kind;
        logic [15:0] src_value;
        logic src_ext;
        csco_kind_e dst_kind;
        logic [15:0] dst_value;
        logic dst_ext;
    } csco_opnd_s;

    // Flag update from the execute stage
    typedef struct packed {
        logic valid;
        csco_op_e op;
        logic byte_op;
        logic [15:0] dst;
        logic [15:0] src;
        logic [15:0] result;
        logic carry;
    } csco_alu_s;

    // Register write-back
    typedef struct packed {
        logic valid;
        logic byte_op;
        logic [3:0] dst_reg;
        logic [15:0] data;
    } csco_wb_s;

endpackage : csco_pkg

//--- verif/csco_exec_model.sv
// Purpose: Behavioural decoder and execute stage that drive the operand unit.
// Assumes: Requests launch just after a rising edge and hold until the edge that takes them.
// Notes: Released lines show inverted data so a stale value can never pass for a fresh one.
module csco_exec_model
    import csco_pkg::*;
(
    // Clock
    input wire logic i_mclk,
    // Requests toward the unit
    output csco_dec_s o_dec,
    output csco_alu_s o_alu,
    output csco_wb_s o_wb,
    output logic o_pc_step,
    output logic o_pc_load,
    output logic [15:0] o_pc_value
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet lines at time zero
    initial begin
        o_dec = '0;
        o_alu = '0;
        o_wb = '0;
        o_pc_step = 1'b0;
        o_pc_load = 1'b0;
        o_pc_value = 16'h0000;
    end

    // Decode request, may follow another at the very next edge
    task automatic send_dec(input logic b, input logic [3:0] sr, input logic [1:0] sm, input logic [3:0] dr,
                            input logic dm);
        @(posedge i_mclk);
        o_dec <= '{1'b1, b, sr, sm, dr, dm};
    endtask : send_dec

    task automatic drop_dec();
        @(posedge i_mclk);
        o_dec <= {1'b0, ~o_dec[$bits(csco_dec_s)-2:0]};
    endtask : drop_dec

    // Register write-back, one edge
    task automatic write_reg(input logic b, input logic [3:0] r, input logic [15:0] d);
        @(posedge i_mclk);
        o_wb <= '{1'b1, b, r, d};
        @(posedge i_mclk);
        o_wb <= {1'b0, ~o_wb[$bits(csco_wb_s)-2:0]};
    endtask : write_reg

    // Flag update from a finished operation
    task automatic send_alu(input csco_alu_s a);
        @(posedge i_mclk);
        o_alu <= a;
        @(posedge i_mclk);
        o_alu <= {1'b0, ~o_alu[$bits(csco_alu_s)-2:0]};
    endtask : send_alu

    // Program counter load or step pulse
    task automatic pc_ctl(input logic ld, input logic st, input logic [15:0] v);
        @(posedge i_mclk);
        o_pc_load <= ld;
        o_pc_step <= st;
        o_pc_value <= v;
        @(posedge i_mclk);
        o_pc_load <= 1'b0;
        o_pc_step <= 1'b0;
        o_pc_value <= ~v;
    endtask : pc_ctl
endmodule : csco_exec_model

//--- verif/csco_unit_tb_top.sv
// Purpose: Self-checking bench for the status, constant and operand unit.
// Assumes: Partner model launches requests; results are sampled at the falling edge.
// Notes: Operand answers are matched in order against a queue of notes.
module csco_unit_tb_top
    import csco_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        csco_kind_e kind;
        logic [15:0] val;
        logic ext;
        csco_kind_e dkind;
        logic [15:0] dval;
        logic dext;
    } csco_tb_note_s;

    csco_tb_note_s notes_q[$];
    int n_fail = 0;
    int checks_done = 0;
    int seed = 32'hc0a3;
    int cycles = 0;
    logic [15:0] gv [16];
    logic [15:0] kc3 [4] = '{16'h0000, 16'h0001, 16'h0002, 16'hffff};
    csco_alu_s alu_tab [5] = '{'{1'b1, CSCO_OP_ADD, 1'b0, 16'h7fff, 16'h0001, 16'h8000, 1'b0},
        '{1'b1, CSCO_OP_SUB, 1'b0, 16'h8000, 16'h0001, 16'h7fff, 1'b1},
        '{1'b1, CSCO_OP_SUM_WITH_CARRY_INSTR, 1'b1, 16'h0080, 16'h0080, 16'h0000, 1'b1},
        '{1'b1, CSCO_OP_SUBC, 1'b1, 16'h0010, 16'h0020, 16'h00f0, 1'b0},
        '{1'b1, CSCO_OP_OTHER, 1'b0, 16'h1234, 16'h0000, 16'h0000, 1'b0}};
    logic [15:0] psw_tab [5] = '{16'h0104, 16'h0101, 16'h0103, 16'h0004, 16'h0002};
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] drv = 4'h0;
    logic irq = 1'b0;
    csco_dec_s dec;
    csco_alu_s alu;
    csco_wb_s wb;
    csco_opnd_s opnd;
    logic pc_step, pc_load, sub_off, gen_off, lf_off, halt, irq_acc;
    logic [15:0] pc_value, psw, pc;

    // 25 MHz core clock
    initial begin
        forever #20 i_mclk = ~i_mclk;
    end

    csco_exec_model model_u (.i_mclk(i_mclk), .o_dec(dec), .o_alu(alu), .o_wb(wb), .o_pc_step(pc_step),
        .o_pc_load(pc_load), .o_pc_value(pc_value));

    csco_unit dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_dec(dec), .o_opnd(opnd), .i_alu(alu), .i_wb(wb),
        .i_pc_step(pc_step), .i_pc_load(pc_load), .i_pc_value(pc_value), .i_dco_drives_main(drv[3]),
        .i_dco_drives_sub(drv[2]), .i_lfxt_drives_main(drv[1]), .i_lfxt_drives_sub(drv[0]),
        .i_irq_request(irq), .o_processor_status_word(psw), .o_program_counter(pc), .o_sub_clock_off(sub_off),
        .o_dco_gen_off(gen_off), .o_lfxt_off(lf_off), .o_core_halt(halt), .o_irq_accept(irq_acc));

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : cmp_word

    task automatic cmp_opnd(input csco_tb_note_s exp, input csco_opnd_s got);
        checks_done++;
        if ({got.src_kind, got.src_value, got.src_ext, got.dst_kind, got.dst_value, got.dst_ext} !== exp) begin
            n_fail++;
            $display("unexpected operand: expected %h, seen %h", exp, got[$bits(csco_opnd_s)-2:0]);
        end
    endtask : cmp_opnd

    // Launch a decode request and note its answer
    task automatic req(input logic b, input logic [3:0] sr, input logic [1:0] sm, input logic [3:0] dr,
                       input logic dm, input csco_kind_e k, input logic [15:0] v, input logic e,
                       input csco_kind_e dk, input logic [15:0] dv);
        model_u.send_dec(b, sr, sm, dr, dm);
        notes_q.push_back(csco_tb_note_s'{k, v, e, dk, dv, dm});
    endtask : req

    task automatic settle(input string what);
        model_u.drop_dec();
        repeat (3) @(negedge i_mclk);
        $display("test %s done", what);
    endtask : settle

    // Oldest note answers the next operand result; a surplus result is a mismatch
    always @(negedge i_mclk) begin
        if (opnd.valid === 1'b1) begin
            if (notes_q.size() == 0) begin
                cmp_word("unrequested operand", 16'h0000, 16'h0001);
            end else begin
                cmp_opnd(notes_q.pop_front(), opnd);
            end
        end
    end

    // Hang guard, far above the roughly 100 cycles the run needs
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(negedge i_mclk);
        cmp_word("status word", 16'h0000, psw);
        cmp_word("program counter", 16'h0000, pc);
        for (int m = 0; m < 4; m++) begin
            req(1'b0, 4'h3, 2'(m), 4'h4, 1'b1, CSCO_K_CONST, kc3[m], 1'b0, CSCO_K_INDEXED, 16'h0000);
        end
        req(1'b0, 4'h2, 2'h0, 4'h4, 1'b0, CSCO_K_REG, 16'h0000, 1'b0, CSCO_K_REG, 16'h0000);
        req(1'b0, 4'h2, 2'h1, 4'h4, 1'b1, CSCO_K_ABSOLUTE, 16'h0000, 1'b1, CSCO_K_INDEXED, 16'h0000);
        req(1'b0, 4'h2, 2'h2, 4'h2, 1'b1, CSCO_K_CONST, 16'h0004, 1'b0, CSCO_K_ABSOLUTE, 16'h0000);
        req(1'b0, 4'h2, 2'h3, 4'h4, 1'b0, CSCO_K_CONST, 16'h0008, 1'b0, CSCO_K_REG, 16'h0000);
        settle("constants");
        for (int r = 4; r < 16; r++) begin
            gv[r] = 16'($random(seed));
            model_u.write_reg(1'b0, 4'(r), gv[r]);
        end
        for (int r = 4; r < 16; r++) begin
            req(1'b0, 4'(r), 2'h0, 4'(r), 1'b1, CSCO_K_REG, gv[r], 1'b0, CSCO_K_INDEXED, gv[r]);
        end
        req(1'b0, 4'h5, 2'h1, 4'h6, 1'b0, CSCO_K_INDEXED, gv[5], 1'b1, CSCO_K_REG, gv[6]);
        req(1'b0, 4'h5, 2'h2, 4'h4, 1'b1, CSCO_K_INDIRECT, gv[5], 1'b0, CSCO_K_INDEXED, gv[4]);
        req(1'b0, 4'h5, 2'h3, 4'h4, 1'b1, CSCO_K_AUTOINC, gv[5], 1'b0, CSCO_K_INDEXED, gv[4]);
        req(1'b0, 4'h5, 2'h0, 4'h4, 1'b1, CSCO_K_REG, gv[5] + 16'h0002, 1'b0, CSCO_K_INDEXED, gv[4]);
        req(1'b1, 4'h6, 2'h3, 4'h4, 1'b1, CSCO_K_AUTOINC, gv[6], 1'b0, CSCO_K_INDEXED, gv[4]);
        req(1'b1, 4'h6, 2'h0, 4'h4, 1'b1, CSCO_K_REG, (gv[6] + 16'h0001) & 16'h00ff, 1'b0, CSCO_K_INDEXED,
            gv[4]);
        settle("registers");
        model_u.write_reg(1'b0, 4'h3, 16'h1234);
        model_u.write_reg(1'b1, 4'h2, 16'h00ff);
        model_u.write_reg(1'b1, 4'h7, 16'h5a77);
        req(1'b0, 4'h7, 2'h0, 4'h4, 1'b1, CSCO_K_REG, 16'h0077, 1'b0, CSCO_K_INDEXED, gv[4]);
        req(1'b0, 4'h3, 2'h0, 4'h4, 1'b1, CSCO_K_CONST, 16'h0000, 1'b0, CSCO_K_INDEXED, gv[4]);
        req(1'b0, 4'h2, 2'h0, 4'h4, 1'b1, CSCO_K_REG, 16'h0000, 1'b0, CSCO_K_INDEXED, gv[4]);
        settle("byte writes");
        model_u.pc_ctl(1'b1, 1'b0, 16'h1235);
        @(negedge i_mclk);
        cmp_word("program counter", 16'h1234, pc);
        req(1'b0, 4'h0, 2'h1, 4'h0, 1'b1, CSCO_K_SYMBOLIC, 16'h1234, 1'b1, CSCO_K_SYMBOLIC, 16'h1234);
        req(1'b1, 4'h0, 2'h3, 4'h4, 1'b1, CSCO_K_IMMEDIATE, 16'h1234, 1'b1, CSCO_K_INDEXED, gv[4]);
        settle("program counter modes");
        cmp_word("program counter", 16'h1236, pc);
        model_u.pc_ctl(1'b0, 1'b1, 16'h0000);
        @(negedge i_mclk);
        cmp_word("program counter", 16'h1238, pc);
        for (int i = 0; i < 5; i++) begin
            model_u.send_alu(alu_tab[i]);
            @(negedge i_mclk);
            cmp_word("flags", psw_tab[i], psw);
        end
        $display("test flags done");
        model_u.write_reg(1'b0, 4'h2, 16'hfff8);
        @(negedge i_mclk);
        cmp_word("status word", 16'h01f8, psw);
        for (int d = 0; d < 4; d++) begin
            @(posedge i_mclk);
            drv <= {2'(d), 2'(3 - d)};
            irq <= d[0];
            @(negedge i_mclk);
            cmp_word("generator off", {15'h0000, d == 0}, {15'h0000, gen_off});
            cmp_word("crystal off", {15'h0000, d == 3}, {15'h0000, lf_off});
            cmp_word("irq accept", {15'h0000, d[0]}, {15'h0000, irq_acc});
            cmp_word("halt and sub clock", 16'h0003, {14'h0000, halt, sub_off});
        end
        model_u.write_reg(1'b0, 4'h2, 16'h0000);
        @(negedge i_mclk);
        cmp_word("controls cleared", 16'h0000, {12'h000, halt, sub_off, irq_acc, lf_off});
        $display("test status controls done");
        cmp_word("pending notes", 16'h0000, 16'(notes_q.size()));
        print_verdict();
    end
endmodule : csco_unit_tb_top
